/* design/udc_top.sv */
// usb device control, address, status, error and endpoint 0 registers
// assumes a classic wishbone master and a serial engine giving pulses
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`include "udc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module udc_top (
  input  wire logic       mclk,
  input  wire logic       rst,
  // wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // serial engine events, one-cycle pulses
  input  wire logic       sie_resume,
  input  wire logic       sie_bus_reset,
  input  wire logic       sie_activity,
  input  wire logic       sie_error,
  input  wire logic [2:0] sie_error_code,
  input  wire logic       sie_ctr,
  input  wire logic [2:0] sie_ctr_ep,
  input  wire logic       sie_ctr_in,
  input  wire logic       sie_ep0_token,
  input  wire logic [1:0] sie_ep0_pid,
  input  wire logic       sie_ep0_ack_in,
  input  wire logic       sie_ep0_data_ok,
  input  wire logic       sie_ep0_data_pid,
  input  wire logic       sie_ep0_stall,
  // link side outputs
  output logic            usb_resume_drive,
  output logic            usb_regulator_on,
  output logic            usb_regulator_ready,
  output logic            usb_suspend,
  output logic            usb_if_reset,
  output logic            usb_reset_event,
  output logic [6:0]      usb_address,
  output logic [1:0]      usb_tx_state,
  output logic [1:0]      usb_rx_state,
  output logic            usb_tx_toggle,
  output logic            usb_rx_toggle
);

  udc_pkg::udc_state_type s_r;
  udc_pkg::udc_state_type s_nxt;

  function automatic logic [7:0] rd_mux(input udc_pkg::udc_state_type s,
                                        input logic [7:0] a);
    case (a)
      `UDC_ADR_CTRL:  rd_mux = {s.ctrl[7:6], 2'h0, s.ctrl[3:0]};
      `UDC_ADR_DEVADDR: rd_mux = {1'h0, s.addr};
      `UDC_ADR_TSTAT: rd_mux = {s.pid, s.dir, 2'h0, s.epn};
      `UDC_ADR_ERR:   rd_mux = {5'h0, s.err};
      `UDC_ADR_EP0:   rd_mux = {s.ep0_transfer_done, s.dtx, s.stx, 1'h0, s.drx, s.srx};
      `UDC_ADR_ISTAT: rd_mux = {3'h0, s.ist_err, 4'h0};
      default:        rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  logic       wr;
  logic [7:0] wd;
  logic       usb_rst;

  // write lands at the acknowledging edge, request still held
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
              && (s_r.bus == udc_pkg::UDC_ACK);
  assign wd = wb_dat_i[7:0];
  // forced reset acts as bus reset
  assign usb_rst = sie_bus_reset || s_r.ctrl[`UDC_CTRL_RSTFORCE];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_irq = 1'b0;
    // bus slave: ack one cycle after request, drop next
    case (s_r.bus)
      udc_pkg::UDC_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          s_nxt.bus  = udc_pkg::UDC_ACK;
          s_nxt.rdat = rd_mux(s_r, wb_adr_i);
        end
      end
      udc_pkg::UDC_ACK: s_nxt.bus = udc_pkg::UDC_IDLE;
      default:          s_nxt.bus = udc_pkg::UDC_IDLE;
    endcase
    // software writes; reserved bits dropped
    if (wr) begin
      case (wb_adr_i)
        `UDC_ADR_CTRL: s_nxt.ctrl[3:0] = wd[3:0];
        `UDC_ADR_DEVADDR: s_nxt.addr = wd[6:0];
        `UDC_ADR_ISTAT: if (!wd[`UDC_IST_ERR]) s_nxt.ist_err = 1'b0;
        `UDC_ADR_EP0: begin
          if (!wd[`UDC_EP0_CTR]) s_nxt.ep0_transfer_done = 1'b0;
          s_nxt.dtx = wd[`UDC_EP0_DTX];
          s_nxt.stx = wd[5:4];
          s_nxt.drx = wd[`UDC_EP0_DRX];
          s_nxt.srx = wd[1:0];
        end
        default: ;
      endcase
    end
    // error type clears with error flag
    if (!s_nxt.ist_err) s_nxt.err = 3'h0;
    if (sie_error) begin
      s_nxt.ist_err = 1'b1;
      s_nxt.err = sie_error_code;
    end
    if (sie_resume) s_nxt.ctrl[`UDC_CTRL_RESUMED] = 1'b1;
    if (sie_bus_reset) s_nxt.ctrl[`UDC_CTRL_USBRST] = 1'b1;
    if (sie_activity || sie_resume || sie_bus_reset)
      s_nxt.ctrl[`UDC_CTRL_SUSPFORCE] = 1'b0;
    if (sie_ctr) begin
      s_nxt.epn = sie_ctr_ep;
      if (sie_ctr_ep != 3'h0) s_nxt.dir = sie_ctr_in;
    end
    if (sie_ep0_token) s_nxt.pid = sie_ep0_pid;
    if (sie_ep0_ack_in) s_nxt.dtx = ~s_r.dtx;
    if (sie_ep0_data_ok && sie_ep0_data_pid == s_r.drx)
      s_nxt.drx = ~s_r.drx;
    if (sie_ep0_token && sie_ep0_pid == `UDC_PID_SETUP
        && s_r.srx != `UDC_ST_DIS) begin
      s_nxt.dtx = 1'b1;
      s_nxt.drx = 1'b0;
      s_nxt.stx = `UDC_ST_NAK;
      s_nxt.srx = `UDC_ST_NAK;
    end
    if (sie_ctr && sie_ctr_ep == 3'h0) begin
      s_nxt.ep0_transfer_done = 1'b1;
      s_nxt.stx  = `UDC_ST_NAK;
      s_nxt.srx  = `UDC_ST_NAK;
    end
    if (sie_ep0_stall) begin
      s_nxt.stx = `UDC_ST_STALL;
      s_nxt.srx = `UDC_ST_STALL;
    end
    if (usb_rst) begin
      s_nxt.addr = 7'h00;
      s_nxt.dtx  = 1'b0;
      s_nxt.stx  = `UDC_ST_DIS;
      s_nxt.drx  = 1'b0;
      s_nxt.srx  = `UDC_ST_DIS;
    end
    // event on release of forced reset
    s_nxt.reset_force_d = s_r.ctrl[`UDC_CTRL_RSTFORCE];
    if (s_r.reset_force_d && !s_r.ctrl[`UDC_CTRL_RSTFORCE]) s_nxt.rst_irq = 1'b1;
    s_nxt.wake = s_r.ctrl[`UDC_CTRL_RESUME]
                 && s_r.ctrl[`UDC_CTRL_SUSPFORCE];
    s_nxt.vreg_on = !s_nxt.ctrl[`UDC_CTRL_PWRDN];
    if (!s_nxt.vreg_on) s_nxt.settle = 8'h00;
    else if (s_r.settle != 8'(`UDC_SETTLE_CYC))
      s_nxt.settle = s_r.settle + 8'h01;
    // ready flag registered so the pin comes from a flop
    s_nxt.rdy = (s_nxt.settle == 8'(`UDC_SETTLE_CYC));
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.ctrl    <= `UDC_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign wb_ack_o            = (s_r.bus == udc_pkg::UDC_ACK);
  assign wb_dat_o            = {24'h0, s_r.rdat};
  assign usb_resume_drive    = s_r.wake;
  assign usb_regulator_on    = s_r.vreg_on;
  assign usb_regulator_ready = s_r.rdy;
  assign usb_suspend         = s_r.ctrl[`UDC_CTRL_SUSPFORCE];
  assign usb_if_reset        = s_r.ctrl[`UDC_CTRL_RSTFORCE];
  assign usb_reset_event     = s_r.rst_irq;
  assign usb_address         = s_r.addr;
  assign usb_tx_state        = s_r.stx;
  assign usb_rx_state        = s_r.srx;
  assign usb_tx_toggle       = s_r.dtx;
  assign usb_rx_toggle       = s_r.drx;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_RESUMED_SET: assert property (sie_resume |=> resumed_flag())
    else $error("resume flag not set");
  AST_RESUMED_HOLD: assert property (
    s_r.ctrl[7] |=> s_r.ctrl[7])
    else $error("resume flag lost");
  AST_BUSRST_HOLD: assert property (
    s_r.ctrl[6] |=> s_r.ctrl[6])
    else $error("reset flag lost");
  AST_USBRST_SET: assert property (sie_bus_reset |=> s_r.ctrl[6])
    else $error("reset flag not set");
  AST_WAKE: assert property (
    (s_r.ctrl[3] && s_r.ctrl[1]) |=> usb_resume_drive)
    else $error("resume drive missing");
  AST_WAKE_OFF: assert property (
    !(s_r.ctrl[3] && s_r.ctrl[1]) |=> !usb_resume_drive)
    else $error("resume drive stuck");
  AST_REG: assert property (
    usb_regulator_on == !s_r.ctrl[2])
    else $error("regulator state wrong");
  AST_REG_OFF_READY: assert property (
    !usb_regulator_on |-> !usb_regulator_ready)
    else $error("ready while regulator off");
  AST_SUSP_CLR: assert property (sie_activity |=> !usb_suspend)
    else $error("suspend not cleared");
  AST_RSTFORCE_EVT: assert property (
    $fell(s_r.ctrl[0]) |=> usb_reset_event)
    else $error("reset event missing");
  AST_RST_EVT_PULSE: assert property (
    usb_reset_event |=> !usb_reset_event)
    else $error("reset event too long");

  // ------------------------------------------------------------------
  // assertions: register read data
  // ------------------------------------------------------------------
  AST_CTRL_RSV: assert property (
    (wb_ack_o && $past(wb_adr_i) == `UDC_ADR_CTRL)
    |-> wb_dat_o[5:4] == 2'h0)
    else $error("control reserved bits set");
  AST_ADDR_RSV: assert property (
    (wb_ack_o && $past(wb_adr_i) == `UDC_ADR_DEVADDR)
    |-> !wb_dat_o[7])
    else $error("address reserved bit set");
  AST_TSTAT_RSV: assert property (
    (wb_ack_o && $past(wb_adr_i) == `UDC_ADR_TSTAT)
    |-> wb_dat_o[4:3] == 2'h0)
    else $error("status reserved bits set");
  AST_ERR_RSV: assert property (
    (wb_ack_o && $past(wb_adr_i) == `UDC_ADR_ERR)
    |-> wb_dat_o[7:3] == 5'h00)
    else $error("error type reserved bits set");
  AST_EP0_RSV: assert property (
    (wb_ack_o && $past(wb_adr_i) == `UDC_ADR_EP0)
    |-> !wb_dat_o[3])
    else $error("endpoint reserved bit set");

  // ------------------------------------------------------------------
  // assertions: status, endpoint 0 and bus acknowledge
  // ------------------------------------------------------------------
  AST_ADDR_CLR: assert property (usb_rst |=> usb_address == 7'h00)
    else $error("address not cleared");
  AST_EP0_RST: assert property (
    usb_rst |=> usb_tx_state == 2'h0 && usb_rx_state == 2'h0
    && !usb_tx_toggle && !usb_rx_toggle)
    else $error("endpoint 0 not cleared by reset");
  AST_PID_LOAD: assert property (
    sie_ep0_token |=> s_r.pid == $past(sie_ep0_pid))
    else $error("token pid not stored");
  AST_DIR_LOAD: assert property (
    (sie_ctr && sie_ctr_ep != 3'h0) |=> s_r.dir == $past(sie_ctr_in))
    else $error("direction not stored");
  AST_DIR_KEEP: assert property (
    (sie_ctr && sie_ctr_ep == 3'h0) |=> $stable(s_r.dir))
    else $error("direction changed by endpoint 0");
  AST_EPN_LOAD: assert property (
    sie_ctr |=> s_r.epn == $past(sie_ctr_ep))
    else $error("endpoint number not stored");
  AST_ERR_CLR: assert property (
    !s_r.ist_err |-> s_r.err == 3'h0)
    else $error("error type kept without flag");
  AST_DONE_SET: assert property (
    (sie_ctr && sie_ctr_ep == 3'h0) |=> s_r.ep0_transfer_done)
    else $error("done flag not set");
  AST_TX_TOGGLE: assert property (
    (sie_ep0_ack_in && !usb_rst && !sie_ep0_token && !wr)
    |=> usb_tx_toggle != $past(usb_tx_toggle))
    else $error("transmit toggle not flipped");
  AST_SETUP_NAK: assert property (
    (sie_ep0_token && sie_ep0_pid == 2'h3 && s_r.srx != 2'h0
     && !usb_rst && !sie_ep0_stall)
    |=> usb_tx_state == 2'h2 && usb_rx_state == 2'h2
    && usb_tx_toggle && !usb_rx_toggle)
    else $error("setup not handled");
  AST_RX_TOGGLE: assert property (
    (sie_ep0_data_ok && sie_ep0_data_pid == s_r.drx && !usb_rst
     && !sie_ep0_token && !wr) |=> usb_rx_toggle != $past(usb_rx_toggle))
    else $error("receive toggle not flipped");
  AST_RX_KEEP: assert property (
    (sie_ep0_data_ok && sie_ep0_data_pid != s_r.drx && !usb_rst
     && !sie_ep0_token && !wr) |=> $stable(usb_rx_toggle))
    else $error("receive toggle flipped on mismatch");
  AST_EP0_NAK: assert property (
    (sie_ctr && sie_ctr_ep == 3'h0 && !usb_rst && !sie_ep0_stall)
    |=> usb_tx_state == 2'h2 && usb_rx_state == 2'h2 && s_r.ep0_transfer_done)
    else $error("ep0 not nak after transfer");
  AST_STALL: assert property (
    (sie_ep0_stall && !usb_rst) |=> usb_tx_state == 2'h1)
    else $error("stall not set");
  AST_STALL_RX: assert property (
    (sie_ep0_stall && !usb_rst) |=> usb_rx_state == 2'h1)
    else $error("receive stall not set");
  AST_ERR: assert property (
    sie_error |=> s_r.err == $past(sie_error_code))
    else $error("error code not loaded");
  AST_WB_ACK: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");
  AST_NO_ACK: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  COV_SETUP: cover property (sie_ep0_token && sie_ep0_pid == 2'h3);
  COV_RSTFORCE: cover property ($fell(s_r.ctrl[0]));
  COV_STALL: cover property (sie_ep0_stall);
  COV_ERR: cover property (sie_error);
  COV_SETTLE: cover property ($rose(usb_regulator_ready));

  function automatic logic resumed_flag();
    resumed_flag = s_r.ctrl[7];
  endfunction : resumed_flag

endmodule : udc_top

`default_nettype wire

/* design/udc_consts.svh */
// constants for the usb device control and endpoint 0 status block
// assumes inclusion by the udc top module
`ifndef UDC_CONSTS_SVH
`define UDC_CONSTS_SVH

// register byte addresses (word aligned)
`define UDC_ADR_CTRL     8'h00
`define UDC_ADR_DEVADDR  8'h04
`define UDC_ADR_TSTAT    8'h08
`define UDC_ADR_ERR      8'h0c
`define UDC_ADR_EP0      8'h10
`define UDC_ADR_ISTAT    8'h14

// reset values
`define UDC_CTRL_RST     8'h06
`define UDC_EP0_RST      8'h00

// control register fields
`define UDC_CTRL_RESUMED   7
`define UDC_CTRL_USBRST    6
`define UDC_CTRL_RESUME    3
`define UDC_CTRL_PWRDN     2
`define UDC_CTRL_SUSPFORCE 1
`define UDC_CTRL_RSTFORCE  0

// endpoint 0 register fields
`define UDC_EP0_CTR      7
`define UDC_EP0_DTX      6
`define UDC_EP0_DRX      2

// handshake state codes
`define UDC_ST_DIS       2'h0
`define UDC_ST_STALL     2'h1
`define UDC_ST_NAK       2'h2
`define UDC_ST_VALID     2'h3

// token pid high bits
`define UDC_PID_OUT      2'h0
`define UDC_PID_IN       2'h2
`define UDC_PID_SETUP    2'h3

// interrupt status error bit
`define UDC_IST_ERR      4

// regulator settle time
`define UDC_SETTLE_NS    3000
`define UDC_CLK_NS       25
`define UDC_SETTLE_CYC   ((`UDC_SETTLE_NS + `UDC_CLK_NS - 1) / `UDC_CLK_NS)

`endif

/* design/udc_pkg.sv */
// types for the usb device control and endpoint 0 status block
// assumes nothing of its surroundings
package udc_pkg;

  typedef enum logic [1:0] {
    UDC_IDLE,
    UDC_ACK
  } udc_bus_type;

  typedef struct packed {
    udc_bus_type bus;
    logic [7:0]  rdat;
    logic [7:0]  ctrl;
    logic [6:0]  addr;
    logic [1:0]  pid;
    logic        dir;
    logic [2:0]  epn;
    logic [2:0]  err;
    logic        ist_err;
    logic        ep0_transfer_done;
    logic        dtx;
    logic [1:0]  stx;
    logic        drx;
    logic [1:0]  srx;
    logic        reset_force_d;
    logic        rst_irq;
    logic        wake;
    logic        vreg_on;
    logic [7:0]  settle;
    logic        rdy;
  } udc_state_type;

endpackage : udc_pkg

/* tb/udc_host_model.sv */
// serial engine stand-in: one-cycle event pulses with their qualifiers
// assumes a free-running mclk from the bench; events are sent one by one
`timescale 1ns/10ps
`default_nettype none

module udc_host_model (
  input  wire logic        mclk,
  output var  logic [12:0] sie
);
  // ------------------------------------------------------------
  // event pulse
  // ------------------------------------------------------------
  // bits 8:0 strobe by kind, 11:9 code/endpoint/pid, 12 direction/pid
  initial sie = 13'h0000;

  task automatic ev(input int k, input logic [2:0] a, input logic b,
                    input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    sie <= {b, a, 9'h000} | (13'h0001 << k);
    @(posedge mclk);
    // qualifiers released: show the inverse, never the old value
    sie <= {~b, ~a, 9'h000};
  endtask : ev
endmodule : udc_host_model

`default_nettype wire

/* tb/usb_device_ctrl_ep0_status_tb_top.sv */
// self-checking bench for the usb control and endpoint 0 registers
// assumes udc_top and the serial engine stand-in udc_host_model
`timescale 1ns/10ps
`default_nettype none

module usb_device_ctrl_ep0_status_tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [12:0] sie;
  logic        usb_resume_drive, usb_regulator_on, usb_regulator_ready;
  logic        usb_suspend, usb_if_reset, usb_reset_event;
  logic        usb_tx_toggle, usb_rx_toggle, b;
  logic [6:0]  usb_address;
  logic [1:0]  usb_tx_state, usb_rx_state;
  logic [7:0]  d;
  logic [2:0]  ec [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [31:0] expq [$];
  int          n_fail = 0, tests_run = 0, seed = 67411, i, n_revt = 0;

  always #12.5 mclk = ~mclk;

  udc_top dut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sie_resume(sie[0]), .sie_bus_reset(sie[1]), .sie_activity(sie[2]),
    .sie_error(sie[3]), .sie_error_code(sie[11:9]), .sie_ctr(sie[4]),
    .sie_ctr_ep(sie[11:9]), .sie_ctr_in(sie[12]), .sie_ep0_token(sie[5]),
    .sie_ep0_pid(sie[10:9]), .sie_ep0_ack_in(sie[6]),
    .sie_ep0_data_ok(sie[7]), .sie_ep0_data_pid(sie[12]),
    .sie_ep0_stall(sie[8]), .usb_resume_drive, .usb_regulator_on,
    .usb_regulator_ready, .usb_suspend, .usb_if_reset, .usb_reset_event,
    .usb_address, .usb_tx_state, .usb_rx_state, .usb_tx_toggle,
    .usb_rx_toggle);

  udc_host_model host (.mclk, .sie);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    if (!w) expq.push_back({24'h0, v});
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic st();
    repeat (3) @(posedge mclk);
    #1;
  endtask : st

  task automatic tally_and_finish();
    if (expq.size() != 0) n_fail++;
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // read data taken at the acknowledging edge
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (expq.size() == 0) n_fail++;
      else chk(wb_dat_o, expq.pop_front());
    end
    if (usb_reset_event === 1'b1) n_revt++;
  end

  initial begin
    #2000000;
    n_fail++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    st(); chk({usb_regulator_on, usb_suspend}, 2'b01);
    wb(0, 8'h00, 8'h06);
    wb(0, 8'h04, 8'h00);
    wb(0, 8'h08, 8'h00);
    wb(0, 8'h0c, 8'h00);
    wb(0, 8'h10, 8'h00);
    wb(1, 8'h18, 8'hff); wb(0, 8'h18, 8'h00);
    wb(1, 8'h00, 8'h30); wb(0, 8'h00, 8'h00);
    chk(usb_regulator_ready, 1'b0);
    st(); chk({usb_regulator_on, usb_suspend}, 2'b10);
    repeat (120) @(posedge mclk);
    #1 chk(usb_regulator_ready, 1'b1);
    d = $random(seed);
    wb(1, 8'h04, d); wb(0, 8'h04, {1'b0, d[6:0]});
    st(); chk(usb_address, d[6:0]);
    wb(1, 8'h08, 8'hff); wb(0, 8'h08, 8'h00);
    wb(1, 8'h0c, 8'hff); wb(0, 8'h0c, 8'h00);
    host.ev(1, 3'h0, 1'b0, 2); wb(0, 8'h04, 8'h00);
    host.ev(0, 3'h0, 1'b0, 0); wb(0, 8'h00, 8'hc0);
    wb(1, 8'h10, 8'h33); host.ev(5, 3'h3, 1'b0, 0);
    wb(0, 8'h10, 8'h62);
    host.ev(4, 3'h0, 1'b0, 1); wb(0, 8'h10, 8'he2);
    wb(0, 8'h08, 8'hc0);
    host.ev(6, 3'h0, 1'b0, 0); host.ev(7, 3'h0, 1'b0, 3);
    host.ev(7, 3'h0, 1'b0, 0); wb(0, 8'h10, 8'ha6);
    for (i = 2; i >= 0; i -= 2) begin
      host.ev(5, i[2:0], 1'b0, 0); host.ev(4, 3'h0, 1'b0, 0);
      wb(0, 8'h08, {i[1:0], 6'h00});
    end
    wb(1, 8'h10, 8'h4c); wb(0, 8'h10, 8'h44);
    host.ev(8, 3'h0, 1'b0, 0); wb(0, 8'h10, 8'h55);
    chk({usb_tx_state, usb_rx_state, usb_tx_toggle, usb_rx_toggle},
        6'h17);
    for (i = 1; i < 6; i++) begin
      b = $random(seed);
      host.ev(4, i[2:0], b, i);
      wb(0, 8'h08, {2'b00, b, 2'b00, i[2:0]});
    end
    for (i = 0; i < 6; i++) begin
      host.ev(3, ec[i], 1'b0, 0); wb(0, 8'h0c, {5'h00, ec[i]});
      wb(1, 8'h14, 8'h00); wb(0, 8'h0c, 8'h00);
    end
    wb(1, 8'h00, 8'h01);
    st(); chk({usb_if_reset, usb_address}, 8'h80);
    wb(0, 8'h10, 8'h00);
    n_revt = 0;
    wb(1, 8'h00, 8'h00); st(); st(); chk(n_revt, 1);
    wb(1, 8'h00, 8'h0a);
    st(); chk({usb_resume_drive, usb_suspend}, 2'b11);
    host.ev(2, 3'h0, 1'b0, 0); wb(0, 8'h00, 8'hc8);
    st(); chk({usb_resume_drive, usb_suspend}, 2'b00);
    tally_and_finish();
  end
endmodule : usb_device_ctrl_ep0_status_tb_top

`default_nettype wire
